/* File: pkg/aqx_pkg.sv */
// constants, types and field layout for the add/quick/extend/and execute block
// What this block does
// - immediate add operand: byte low of word, word whole, long next two words
// - immediate add destination must be data alterable; An, immediate, PC-relative invalid
// - quick add adds a constant one to eight, size byte, word or long
// - quick add three-bit field: zero means eight, one to seven used directly
// - quick add to An: word/long only, full 32 bits, flags untouched
// - quick add destination must be alterable; immediate and PC-relative invalid
// - size field 00 byte, 01 word, 10 long
// - quick add flags: C carry, V overflow, N sign, Z zero, X copies C
// - add with extend sums source, destination and X, all three sizes
// - add with extend: Z cleared if nonzero else kept; C V N follow; X=C
// - add with extend mode bit: 0 register to register, 1 predecrement memory
// - add with extend: bits 11-9 destination, bits 2-0 source register
// - logical and: N msb, Z zero, V and C cleared, X unchanged
// - and opmode 000/001/010 to register, 100/101/110 to effective address
package aqx_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OPCODE = 8'h04;
  localparam logic [7:0] OFF_EXT0 = 8'h08;
  localparam logic [7:0] OFF_EXT1 = 8'h0c;
  localparam logic [7:0] OFF_SRC = 8'h10;
  localparam logic [7:0] OFF_DST = 8'h14;
  localparam logic [7:0] OFF_CCR = 8'h18;
  localparam logic [7:0] OFF_RESULT = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam int CTRL_GO = 0;
  // ----------------------------------------------------------------
  // opcode fields
  // ----------------------------------------------------------------
  localparam logic [7:0] TOP_IMM_ADD = 8'h06;
  localparam logic [3:0] GRP_QUICK = 4'h5;
  localparam logic [3:0] GRP_AND = 4'hc;
  localparam logic [3:0] GRP_ADD_WITH_EXTEND = 4'hd;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_BAD = 2'h3;
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] REG_ABS_L = 3'h1;
  localparam logic [2:0] REG_IMM = 3'h4;
  localparam logic [2:0] QUICK_ZERO = 3'h0;
  localparam logic [31:0] QUICK_EIGHT = 32'h0000_0008;
  // ----------------------------------------------------------------
  // alignment shifts, msb of each size moved to bit 31
  // ----------------------------------------------------------------
  localparam logic [4:0] SH_BYTE = 5'h18;
  localparam logic [4:0] SH_WORD = 5'h10;
  localparam logic [4:0] SH_LONG = 5'h00;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [4:0] CCR_RESET = 5'h00;

  typedef enum logic [2:0] {OP_NONE, OP_IMM_ADD, OP_QUICK_ADD, OP_ADD_WITH_EXTEND, OP_AND} aqx_op_t;
  typedef enum logic {ST_IDLE, ST_EXEC} aqx_state_t;
  typedef struct packed {
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } aqx_ccr_t;
  typedef struct packed {
    logic [1:0] size;
    logic [2:0] src_num;
    logic [2:0] dst_num;
    logic to_ea;
    logic predec;
    logic to_areg;
    aqx_op_t op;
    logic done;
    logic valid;
  } aqx_stat_t;
endpackage

/* File: rtl/aqx_exec.sv */
// execute block for immediate add, quick add, add with extend and logical and
`timescale 1ns/10ps
`default_nettype none
module aqx_exec (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] opcode_r;
  logic [15:0] ext0_r;
  logic [15:0] ext1_r;
  logic [31:0] src_r;
  logic [31:0] dst_r;
  logic [31:0] result_r;
  aqx_pkg::aqx_ccr_t ccr_r;
  aqx_pkg::aqx_stat_t stat_r;
  aqx_pkg::aqx_state_t state_r;
  aqx_pkg::aqx_state_t state_nxt;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: the answer is registered so every output is a flop
  wire logic acc = PSEL_I & PENABLE_I;
  wire logic first = acc & ~pready_r;
  wire logic fin = acc & pready_r;
  wire logic sel_ctrl = PADDR_I == aqx_pkg::OFF_CTRL;
  wire logic sel_opc = PADDR_I == aqx_pkg::OFF_OPCODE;
  wire logic sel_ext0 = PADDR_I == aqx_pkg::OFF_EXT0;
  wire logic sel_ext1 = PADDR_I == aqx_pkg::OFF_EXT1;
  wire logic sel_src = PADDR_I == aqx_pkg::OFF_SRC;
  wire logic sel_dst = PADDR_I == aqx_pkg::OFF_DST;
  wire logic sel_ccr = PADDR_I == aqx_pkg::OFF_CCR;
  wire logic sel_res = PADDR_I == aqx_pkg::OFF_RESULT;
  wire logic sel_stat = PADDR_I == aqx_pkg::OFF_STATUS;
  wire logic hit = sel_ctrl | sel_opc | sel_ext0 | sel_ext1 | sel_src | sel_dst | sel_ccr
                   | sel_res | sel_stat;
  wire logic wr = fin & PWRITE_I & hit;
  wire logic go = wr & sel_ctrl & PWDATA_I[aqx_pkg::CTRL_GO];
  wire logic [31:0] rd_mux = sel_opc ? {16'h0000, opcode_r} :
                             sel_ext0 ? {16'h0000, ext0_r} :
                             sel_ext1 ? {16'h0000, ext1_r} :
                             sel_src ? src_r :
                             sel_dst ? dst_r :
                             sel_ccr ? {27'h0, ccr_r} :
                             sel_res ? result_r :
                             sel_stat ? {16'h0000, stat_r} : aqx_pkg::ZERO32;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire logic [3:0] grp = opcode_r[15:12];
  wire logic [2:0] ea_mode = opcode_r[5:3];
  wire logic [2:0] ea_reg = opcode_r[2:0];
  wire logic [2:0] reg_hi = opcode_r[11:9];
  wire logic [2:0] opmode = opcode_r[8:6];
  wire logic [1:0] sz_field = opcode_r[7:6];
  wire logic sz_ok = sz_field != aqx_pkg::SZ_BAD;
  wire logic abs_ok = (ea_mode == aqx_pkg::MODE_EXT) & (ea_reg <= aqx_pkg::REG_ABS_L);
  // memory alterable: register-indirect family or absolute short/long
  wire logic mem_alt = ((ea_mode != aqx_pkg::MODE_DREG) & (ea_mode != aqx_pkg::MODE_AREG)
                        & (ea_mode != aqx_pkg::MODE_EXT)) | abs_ok;
  wire logic data_alt = mem_alt | (ea_mode == aqx_pkg::MODE_DREG);
  wire logic data_src = (ea_mode != aqx_pkg::MODE_AREG)
                        & ~((ea_mode == aqx_pkg::MODE_EXT) & (ea_reg > aqx_pkg::REG_IMM));
  wire logic is_imm = opcode_r[15:8] == aqx_pkg::TOP_IMM_ADD;
  wire logic is_quick = (grp == aqx_pkg::GRP_QUICK) & ~opcode_r[8];
  wire logic is_add_with_extend = (grp == aqx_pkg::GRP_ADD_WITH_EXTEND) & opcode_r[8] & (opcode_r[5:4] == 2'b00);
  wire logic is_and = grp == aqx_pkg::GRP_AND;
  wire logic and_to_ea = opmode[2];
  wire logic quick_areg = is_quick & (ea_mode == aqx_pkg::MODE_AREG);
  wire logic imm_ok = is_imm & sz_ok & data_alt;
  // address register only as word or long, all else alterable
  wire logic quick_ok = is_quick & sz_ok & (data_alt | (quick_areg & (sz_field != aqx_pkg::SZ_BYTE)));
  wire logic add_with_extend_ok = is_add_with_extend & sz_ok;
  wire logic and_ok = is_and & (opmode[1:0] != aqx_pkg::SZ_BAD)
                      & (and_to_ea ? mem_alt : data_src);
  wire logic dec_ok = imm_ok | quick_ok | add_with_extend_ok | and_ok;
  wire logic [1:0] size = is_and ? opmode[1:0] : sz_field;
  wire aqx_pkg::aqx_op_t op = imm_ok ? aqx_pkg::OP_IMM_ADD :
                              quick_ok ? aqx_pkg::OP_QUICK_ADD :
                              add_with_extend_ok ? aqx_pkg::OP_ADD_WITH_EXTEND :
                              and_ok ? aqx_pkg::OP_AND : aqx_pkg::OP_NONE;
  // extend add: destination in bits 11-9, source in bits 2-0
  wire logic [2:0] dst_num = (is_add_with_extend | (is_and & ~and_to_ea)) ? reg_hi : ea_reg;
  wire logic [2:0] src_num = (is_and & and_to_ea) ? reg_hi : ea_reg;
  wire logic predec = is_add_with_extend & opcode_r[3];

  // ----------------------------------------------------------------
  // operands
  // ----------------------------------------------------------------
  wire logic [31:0] imm_val = (sz_field == aqx_pkg::SZ_BYTE) ? {24'h000000, ext0_r[7:0]} :
                              (sz_field == aqx_pkg::SZ_WORD) ? {16'h0000, ext0_r} :
                              {ext0_r, ext1_r};
  wire logic [31:0] quick_val = (reg_hi == aqx_pkg::QUICK_ZERO) ? aqx_pkg::QUICK_EIGHT
                                : {29'h0, reg_hi};
  wire logic [31:0] op_a = is_imm ? imm_val : is_quick ? quick_val : src_r;
  wire logic [31:0] op_b = dst_r;
  wire logic cin = is_add_with_extend & ccr_r.x;
  wire logic [4:0] sh = (size == aqx_pkg::SZ_BYTE) ? aqx_pkg::SH_BYTE :
                        (size == aqx_pkg::SZ_WORD) ? aqx_pkg::SH_WORD : aqx_pkg::SH_LONG;

  // ----------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------
  // operands are left-aligned so one 32-bit adder gives carry and
  // overflow for every size without per-size carry taps
  wire logic [31:0] a_al = op_a << sh;
  wire logic [31:0] b_al = op_b << sh;
  wire logic [31:0] c_al = {31'h0, cin} << sh;
  wire logic [32:0] sum = {1'b0, a_al} + {1'b0, b_al} + {1'b0, c_al};
  wire logic [31:0] and_al = a_al & b_al;
  wire logic [31:0] res_al = is_and ? and_al : sum[31:0];
  wire logic [31:0] size_mask = aqx_pkg::ALL_ONES >> sh;
  wire logic [31:0] res_low = res_al >> sh;
  // a sized write into a register keeps its upper bits
  wire logic [31:0] merged = (op_b & ~size_mask) | (res_low & size_mask);
  wire logic [31:0] full_sum = op_b + op_a;
  wire logic [31:0] result_nxt = quick_areg ? full_sum : merged;
  wire logic res_zero = res_al == aqx_pkg::ZERO32;
  wire logic add_v = (a_al[31] == b_al[31]) & (res_al[31] != a_al[31]);
  wire logic add_c = sum[32];

  // ----------------------------------------------------------------
  // condition codes
  // ----------------------------------------------------------------
  aqx_pkg::aqx_ccr_t ccr_nxt;
  always_comb begin
    ccr_nxt = ccr_r;
    case (op)
      aqx_pkg::OP_IMM_ADD: begin
        ccr_nxt = '{x: add_c, n: res_al[31], z: res_zero, v: add_v, c: add_c};
      end
      aqx_pkg::OP_QUICK_ADD: begin
        if (!quick_areg) begin
          ccr_nxt = '{x: add_c, n: res_al[31], z: res_zero, v: add_v, c: add_c};
        end
      end
      aqx_pkg::OP_ADD_WITH_EXTEND: begin
        // zero only ever clears, so a chain of words tests zero as a whole
        ccr_nxt = '{x: add_c, n: res_al[31], z: ccr_r.z & res_zero, v: add_v, c: add_c};
      end
      aqx_pkg::OP_AND: begin
        ccr_nxt = '{x: ccr_r.x, n: res_al[31], z: res_zero, v: 1'b0, c: 1'b0};
      end
      default: begin
        ccr_nxt = ccr_r;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    case (state_r)
      aqx_pkg::ST_IDLE: state_nxt = go ? aqx_pkg::ST_EXEC : aqx_pkg::ST_IDLE;
      aqx_pkg::ST_EXEC: state_nxt = aqx_pkg::ST_IDLE;
      default: state_nxt = aqx_pkg::ST_IDLE;
    endcase
  end
  wire logic exec = state_r == aqx_pkg::ST_EXEC;
  wire logic commit = exec & dec_ok;

  aqx_pkg::aqx_stat_t stat_nxt;
  always_comb begin
    stat_nxt = stat_r;
    if (exec) begin
      stat_nxt.valid = dec_ok;
      stat_nxt.done = 1'b1;
      stat_nxt.op = op;
      stat_nxt.to_areg = quick_areg & dec_ok;
      stat_nxt.predec = predec;
      stat_nxt.to_ea = (is_and & and_to_ea) | ((is_imm | is_quick) & ~quick_areg
                       & (ea_mode != aqx_pkg::MODE_DREG));
      stat_nxt.dst_num = dst_num;
      stat_nxt.src_num = src_num;
      stat_nxt.size = size;
    end else if (go) begin
      stat_nxt.done = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= aqx_pkg::ZERO32;
      state_r <= aqx_pkg::ST_IDLE;
      stat_r <= '0;
    end else begin
      pready_r <= first;
      pslverr_r <= first & ~hit;
      prdata_r <= (first & ~PWRITE_I) ? rd_mux : prdata_r;
      state_r <= state_nxt;
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      opcode_r <= 16'h0000;
      ext0_r <= 16'h0000;
      ext1_r <= 16'h0000;
      src_r <= aqx_pkg::ZERO32;
    end else begin
      opcode_r <= (wr & sel_opc) ? PWDATA_I[15:0] : opcode_r;
      ext0_r <= (wr & sel_ext0) ? PWDATA_I[15:0] : ext0_r;
      ext1_r <= (wr & sel_ext1) ? PWDATA_I[15:0] : ext1_r;
      src_r <= (wr & sel_src) ? PWDATA_I : src_r;
    end
  end

  // execution wins over a software write landing in the same cycle
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dst_r <= aqx_pkg::ZERO32;
      result_r <= aqx_pkg::ZERO32;
      ccr_r <= aqx_pkg::CCR_RESET;
    end else begin
      dst_r <= (wr & sel_dst) ? PWDATA_I : dst_r;
      result_r <= commit ? result_nxt : result_r;
      if (commit) begin
        ccr_r <= ccr_nxt;
      end else if (wr & sel_ccr) begin
        ccr_r <= PWDATA_I[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;

endmodule // aqx_exec
`default_nettype wire

/* File: verification/aqx_exec_properties.sv */
// apb-side concurrent checks for the execute block
`timescale 1ns/10ps
`default_nettype none
module aqx_props (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  // apb slave side
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!ARST_N_I);
  // first access-phase edge: the answer is not out yet
  wire logic first_acc = PSEL_I && PENABLE_I && !PREADY_O;
  wire logic mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= aqx_pkg::OFF_STATUS);
  wire logic rd_done = PREADY_O && !PWRITE_I;
  one_wait_a: assert property (first_acc |=> PREADY_O) else $error("answer not one cycle after access");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O) else $error("ready held past one cycle");
  ready_acc_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I))
    else $error("ready outside an access phase");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
  unmapped_err_a: assert property (first_acc && !mapped |=> PSLVERR_O) else $error("unmapped access not refused");
  mapped_ok_a: assert property (first_acc && mapped |=> !PSLVERR_O) else $error("mapped access refused");
  err_zero_a: assert property (rd_done && PSLVERR_O |-> PRDATA_O == 32'h0) else $error("refused read not zero");
  ctrl_zero_a: assert property (rd_done && PADDR_I == aqx_pkg::OFF_CTRL |-> PRDATA_O == 32'h0)
    else $error("control read not zero");
  ccr_width_a: assert property (rd_done && PADDR_I == aqx_pkg::OFF_CCR |-> PRDATA_O[31:5] == 27'h0)
    else $error("flag register upper bits set");
  rdata_hold_a: assert property ($changed(PRDATA_O) |-> rd_done) else $error("read data moved without a read");
endmodule // aqx_props
bind aqx_exec aqx_props u_props (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O));
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the execute block over apb
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [15:0] op, e0, e1;
    logic [31:0] src, dst;
    logic [4:0] ci;
    logic [31:0] res;
    logic [4:0] co;
    logic [15:0] st, mk;
  } aqx_row_t;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int miscompares, tests_run, cycles;
  aqx_exec dut (.MCLK_I(mclk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));
  // status mask picks the fields that each case pins down; invalid rows keep the last result
  // extra invalid rows: byte quick add to An, quick add to a pc-relative target, quick add with size 11,
  // and a 1101 opcode whose bits 5-4 are not clear; all must leave result and flags alone
  aqx_row_t rows [20] = '{
    '{16'h0602, 16'h12ff, 16'h0, 32'h0, 32'h12345601, 5'h00, 32'h12345600, 5'h15, 16'h07, 16'h1f},
    '{16'h0642, 16'h7fff, 16'h0, 32'h0, 32'haaaa0001, 5'h00, 32'haaaa8000, 5'h0a, 16'h07, 16'h1f},
    '{16'h0682, 16'h1234, 16'h5678, 32'h0, 32'h1, 5'h1f, 32'h12345679, 5'h00, 16'h07, 16'h1f},
    '{16'h060a, 16'h1, 16'h0, 32'h0, 32'h1, 5'h1f, 32'h12345679, 5'h1f, 16'h02, 16'h1f},
    '{16'h063c, 16'h1, 16'h0, 32'h0, 32'h1, 5'h0a, 32'h12345679, 5'h0a, 16'h02, 16'h1f},
    '{16'h0639, 16'h1, 16'h0, 32'h0, 32'h7f, 5'h00, 32'h80, 5'h0a, 16'h07, 16'h1f},
    '{16'h5001, 16'h0, 16'h0, 32'h0, 32'hf8, 5'h00, 32'h0, 5'h15, 16'h0b, 16'h1f},
    '{16'h5e40, 16'h0, 16'h0, 32'h0, 32'hfff0, 5'h1f, 32'hfff7, 5'h08, 16'h0b, 16'h1f},
    '{16'h5448, 16'h0, 16'h0, 32'h0, 32'hffff, 5'h1f, 32'h10001, 5'h1f, 16'h2b, 16'h3f},
    '{16'h5008, 16'h0, 16'h0, 32'h0, 32'h5, 5'h04, 32'h10001, 5'h04, 16'h02, 16'h1f},
    '{16'h527a, 16'h0, 16'h0, 32'h0, 32'h5, 5'h0e, 32'h10001, 5'h0e, 16'h02, 16'h1f},
    '{16'h50c0, 16'h0, 16'h0, 32'h0, 32'h5, 5'h11, 32'h10001, 5'h11, 16'h02, 16'h1f},
    '{16'hd158, 16'h0, 16'h0, 32'h1, 32'h5, 5'h07, 32'h10001, 5'h07, 16'h02, 16'h1f},
    '{16'hd705, 16'h0, 16'h0, 32'h1, 32'h111111fe, 5'h14, 32'h11111100, 5'h15, 16'h2b0f, 16'hffff},
    '{16'hd149, 16'h0, 16'h0, 32'h7fff, 32'h1, 5'h04, 32'h8000, 5'h0a, 16'h484f, 16'hffff},
    '{16'hdf87, 16'h0, 16'h0, 32'hffffffff, 32'h0, 5'h10, 32'h0, 5'h11, 16'hbf0f, 16'hffff},
    '{16'hc403, 16'h0, 16'h0, 32'hf0, 32'h12345680, 5'h13, 32'h12345680, 5'h18, 16'h13, 16'h1f},
    '{16'hc192, 16'h0, 16'h0, 32'h0f0f0f0f, 32'hf0f0f0f0, 5'h03, 32'h0, 5'h04, 16'h93, 16'h9f},
    '{16'hc081, 16'h0, 16'h0, 32'h80000000, 32'hffffffff, 5'h10, 32'h80000000, 5'h18, 16'h13, 16'h1f},
    '{16'hc101, 16'h0, 16'h0, 32'h1, 32'h1, 5'h01, 32'h80000000, 5'h01, 16'h02, 16'h1f}
  };
  // ----------------------------------------------------------------
  // clock, timeout and tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares = miscompares + 1;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask
  // holds the whole request until ready is sampled high; the global timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reset_dut();
    arst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
  endtask
  task automatic run_row(input aqx_row_t r);
    apb(1'b1, aqx_pkg::OFF_OPCODE, {16'h0, r.op});
    apb(1'b1, aqx_pkg::OFF_EXT0, {16'h0, r.e0});
    apb(1'b1, aqx_pkg::OFF_EXT1, {16'h0, r.e1});
    apb(1'b1, aqx_pkg::OFF_SRC, r.src);
    apb(1'b1, aqx_pkg::OFF_DST, r.dst);
    apb(1'b1, aqx_pkg::OFF_CCR, {27'h0, r.ci});
    apb(1'b1, aqx_pkg::OFF_CTRL, 32'h1);
    apb(1'b0, aqx_pkg::OFF_RESULT, 32'h0);
    chk("result", r.res, q);
    apb(1'b0, aqx_pkg::OFF_CCR, 32'h0);
    chk("flags", {27'h0, r.co}, q);
    apb(1'b0, aqx_pkg::OFF_STATUS, 32'h0);
    chk("status", {16'h0, r.st & r.mk}, q & {16'h0, r.mk});
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    miscompares = 0;
    tests_run = 0;
    reset_dut();
    apb(1'b0, aqx_pkg::OFF_STATUS, 32'h0);
    chk("status after reset", 32'h0, q);
    foreach (rows[i]) begin
      run_row(rows[i]);
    end
    apb(1'b1, aqx_pkg::OFF_RESULT, 32'h5a5a);
    apb(1'b0, aqx_pkg::OFF_RESULT, 32'h0);
    chk("result after write", 32'h80000000, q);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    apb(1'b1, 8'h1a, 32'h1f);
    chk("unaligned error", 32'h1, {31'h0, e});
    apb(1'b0, aqx_pkg::OFF_CCR, 32'h0);
    chk("flags kept", 32'h1, q);
    reset_dut();
    apb(1'b0, aqx_pkg::OFF_CCR, 32'h0);
    chk("flags after reset", 32'h0, q);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
